// file: ttxw_timing.v
// Teletext request line windows, active rows and bit capture
`include "ttxw_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ttxw_timing #(
	parameter BITS_EURO  = 360,
	parameter BITS_NABTS = 288,
	parameter BITS_WST60 = 296,
	parameter BIT_PERIOD = 4
) (
	input  wire       clk_sys,
	input  wire       rst_b,
	input  wire       strap_ntsc,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       field_sync,
	input  wire       field_odd,
	input  wire       line_start,
	input  wire       field_rate_select,
	input  wire       second_clock_output_enable,
	input  wire [3:0] request_to_data_delay,
	input  wire       teletext_data_input,
	output reg        shared_request_clock_pin,
	output reg        shared_request_clock_pin_oe,
	output reg        active_row,
	output reg  [1:0] teletext_standard,
	output wire       bit_data,
	output wire       bit_valid,
	input  wire       bit_ready
);
	// Register file
	reg [7:0] odd_request_first_row;
	reg [7:0] odd_request_last_row;
	reg [7:0] even_request_first_row;
	reg [7:0] even_request_last_row;
	reg [7:0] first_active_row;
	reg [7:0] last_active_row;
	reg [7:0] mode;
	reg [15:0] row_mask;

	// Line and request state
	reg [8:0]  row;
	reg        in_window;
	reg        row_enabled;
	reg        teletext_bit_request;
	reg [8:0]  bits_left;
	reg [7:0]  period_cnt;
	reg [20:0] cap_pipe;
	reg        strap_q;
	reg        first_cycle;

	wire       data_sync;
	wire       fill_ready;
	wire       is_525;
	wire       proto_window;
	wire [8:0] add_s;
	wire [8:0] add_e;
	wire [8:0] odd_s;
	wire [8:0] odd_e;
	wire [8:0] evn_s;
	wire [8:0] evn_e;
	wire [8:0] act_s;
	wire [8:0] act_e;
	wire [8:0] pal_row;
	wire [4:0] tap;
	wire       capture;
	wire       pending;
	wire       issue;
	reg  [8:0] line_bits;

	// Window test used for both fields and the active rows
	function in_range;
		input [8:0] r;
		input [8:0] lo;
		input [8:0] hi;
		begin
			in_range = (r >= lo) && (r <= hi);
		end
	endfunction

	ttxw_sync3 u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  (teletext_data_input),
		.level   (data_sync)
	);

	ttxw_buf2 #(.W(1)) u_buf (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_data   (data_sync),
		.in_valid  (capture),
		.in_ready  (fill_ready),
		.out_data  (bit_data),
		.out_valid (bit_valid),
		.out_ready (bit_ready)
	);

	assign is_525       = field_rate_select;
	assign proto_window = mode[`TTXW_B_PROTO];
	assign add_s = is_525 ? `TTXW_ADD_START_525 : `TTXW_ADD_START_625;
	assign add_e = is_525 ? `TTXW_ADD_END_525 : `TTXW_ADD_END_625;

	// Nine-bit row targets, top bits from the mode register
	assign odd_s = {mode[`TTXW_B_ODD_FIRST8], odd_request_first_row} + add_s;
	assign odd_e = {mode[`TTXW_B_ODD_LAST8], odd_request_last_row} + add_e;
	assign evn_s = {mode[`TTXW_B_EVN_FIRST8], even_request_first_row} + add_s;
	assign evn_e = {mode[`TTXW_B_EVN_LAST8], even_request_last_row} + add_e;
	assign act_s = {mode[`TTXW_B_FIRST_ACT8], first_active_row} + add_s;
	assign act_e = {mode[`TTXW_B_LAST_ACT8], last_active_row} + add_e;

	// Mask rows are in 625 counting; 525 rows sit three later
	assign pal_row = row - (add_s - `TTXW_ADD_START_625);

	// Strap is a pin; reaches defaults through a plain register
	always @(posedge clk_sys) begin
		strap_q <= strap_ntsc;
	end

	// Host register writes; strap picks the reset defaults
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			first_cycle <= 1'b1;
			odd_request_first_row  <= `TTXW_R_ODD_FIRST_PAL;
			odd_request_last_row   <= `TTXW_R_LAST_PAL;
			even_request_first_row <= `TTXW_R_EVN_FIRST_PAL;
			even_request_last_row  <= `TTXW_R_LAST_PAL;
			first_active_row <= `TTXW_R_ZERO;
			last_active_row  <= `TTXW_R_ZERO;
			mode             <= `TTXW_R_ZERO;
			row_mask         <= {`TTXW_R_ZERO, `TTXW_R_ZERO};
		end else if (first_cycle) begin
			// First edge after release applies the strap
			first_cycle <= 1'b0;
			if (strap_q) begin
				odd_request_first_row  <= `TTXW_R_ODD_FIRST_NTSC;
				odd_request_last_row   <= `TTXW_R_LAST_NTSC;
				even_request_first_row <= `TTXW_R_EVN_FIRST_NTSC;
				even_request_last_row  <= `TTXW_R_LAST_NTSC;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`TTXW_A_ODD_FIRST: odd_request_first_row  <= reg_wdata;
				`TTXW_A_ODD_LAST:  odd_request_last_row   <= reg_wdata;
				`TTXW_A_EVN_FIRST: even_request_first_row <= reg_wdata;
				`TTXW_A_EVN_LAST:  even_request_last_row  <= reg_wdata;
				`TTXW_A_FIRST_ACT: first_active_row <= reg_wdata;
				`TTXW_A_LAST_ACT:  last_active_row  <= reg_wdata;
				`TTXW_A_MODE:      mode <= reg_wdata;
				`TTXW_A_MASK_LO:   row_mask[7:0]  <= reg_wdata;
				`TTXW_A_MASK_HI:   row_mask[15:8] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data; unmapped subaddresses read zero
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`TTXW_A_ODD_FIRST: reg_rdata <= odd_request_first_row;
				`TTXW_A_ODD_LAST:  reg_rdata <= odd_request_last_row;
				`TTXW_A_EVN_FIRST: reg_rdata <= even_request_first_row;
				`TTXW_A_EVN_LAST:  reg_rdata <= even_request_last_row;
				`TTXW_A_FIRST_ACT: reg_rdata <= first_active_row;
				`TTXW_A_LAST_ACT:  reg_rdata <= last_active_row;
				`TTXW_A_MODE:      reg_rdata <= mode;
				`TTXW_A_STATUS:    reg_rdata <= {field_odd, in_window, active_row,
					teletext_bit_request, bit_valid, 3'h0};
				`TTXW_A_MASK_LO:   reg_rdata <= row_mask[7:0];
				`TTXW_A_MASK_HI:   reg_rdata <= row_mask[15:8];
				default:           reg_rdata <= 8'h00;
			endcase
		end
	end

	// Row counter; field sync loads add_s, so register value zero lands on that row
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			row <= 9'h000;
		end else if (field_sync) begin
			row <= add_s;
		end else if (line_start) begin
			row <= row + 9'h001;
		end
	end

	// Request window for the current field and active rows
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			in_window  <= 1'b0;
			active_row <= 1'b0;
		end else begin
			in_window  <= field_odd ? in_range(row, odd_s, odd_e)
				: in_range(row, evn_s, evn_e);
			active_row <= in_range(row, act_s, act_e);
		end
	end

	// Mask only trims rows already inside the window
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			row_enabled <= 1'b0;
		end else if (in_range(pal_row, `TTXW_MASK_FIRST, `TTXW_MASK_LAST)) begin
			row_enabled <= in_window && !row_mask[pal_row[3:0] - 4'h5];
		end else begin
			row_enabled <= in_window;
		end
	end

	// Standard and bits per line follow the field rate, and the standard bit at 60 Hz
	always @* begin
		if (mode[`TTXW_B_STD] && is_525) begin
			line_bits = BITS_WST60[8:0];
		end else if (is_525) begin
			line_bits = BITS_NABTS[8:0];
		end else begin
			line_bits = BITS_EURO[8:0];
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			teletext_standard <= `TTXW_STD_EURO;
		end else if (!is_525) begin
			teletext_standard <= `TTXW_STD_EURO;
		end else begin
			teletext_standard <= mode[`TTXW_B_STD] ? `TTXW_STD_WST60 : `TTXW_STD_NABTS;
		end
	end

	// Capture tap: source delay, floored at minimum, plus pin flop and sync stages
	// Sampling any earlier would catch the source's stale level
	assign tap     = ((request_to_data_delay < `TTXW_DELAY_MIN) ? {1'b0, `TTXW_DELAY_MIN}
		: {1'b0, request_to_data_delay}) + `TTXW_SYNC_LAT;
	assign capture = cap_pipe[tap];
	assign pending = |cap_pipe;
	// Next bit waits for earlier capture and buffer room, so no bit drops
	assign issue   = (bits_left != 9'h000) && (period_cnt == 8'h00) &&
		!pending && fill_ready;

	// Bit issue sequencer, started at each enabled row
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			bits_left  <= 9'h000;
			period_cnt <= 8'h00;
			cap_pipe   <= 21'h000000;
			teletext_bit_request <= 1'b0;
		end else begin
			cap_pipe <= {cap_pipe[19:0], issue};
			if (line_start) begin
				bits_left  <= row_enabled ? line_bits : 9'h000;
				period_cnt <= 8'h00;
				teletext_bit_request <= 1'b0;
			end else if (issue) begin
				bits_left  <= bits_left - 9'h001;
				period_cnt <= BIT_PERIOD[7:0] - 8'h01;
				teletext_bit_request <= 1'b1;
			end else begin
				if (period_cnt != 8'h00) begin
					period_cnt <= period_cnt - 8'h01;
				end
				// One edge per bit, or held high across the line's bits
				if (!proto_window) begin
					teletext_bit_request <= 1'b0;
				end else if (bits_left == 9'h000 && !pending) begin
					teletext_bit_request <= 1'b0;
				end
			end
		end
	end

	// Pin carries the request only while the second clock is off
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			shared_request_clock_pin    <= 1'b0;
			shared_request_clock_pin_oe <= 1'b0;
		end else begin
			shared_request_clock_pin    <= teletext_bit_request &&
				!second_clock_output_enable;
			shared_request_clock_pin_oe <= !second_clock_output_enable;
		end
	end
endmodule // ttxw_timing
`default_nettype wire

// file: ttxw_consts.vh
// Constants for the teletext line window timing block
//
// Contract
// - Odd field requests start at start plus 4/1
// - Odd field requests end at end plus 3/0
// - Even field requests start at start plus 4/1
// - Even field requests end at end plus 3/0
// - First active row, plus 4/1, bit 4 top
// - Last active row, plus 3/0, bit 6 top
// - Row value zero sits on field sync
// - Standard bit picks NABTS or world teletext at 60 Hz; 50 Hz is European
// - Cleared protocol bit: one bit per rising edge
// - Set protocol bit: request high across each line's bits
// - Sixteen-bit mask disables rows 5 to 20
// - Mask acts only inside request windows
// - Request drives pin only while clock enable low
`ifndef TTXW_CONSTS_VH
`define TTXW_CONSTS_VH

// Register subaddresses
`define TTXW_A_ODD_FIRST 8'h76
`define TTXW_A_ODD_LAST  8'h77
`define TTXW_A_EVN_FIRST 8'h78
`define TTXW_A_EVN_LAST  8'h79
`define TTXW_A_FIRST_ACT 8'h7A
`define TTXW_A_LAST_ACT  8'h7B
`define TTXW_A_MODE      8'h7C
`define TTXW_A_STATUS    8'h7D
`define TTXW_A_MASK_LO   8'h7E
`define TTXW_A_MASK_HI   8'h7F

// Mode register field positions
`define TTXW_B_STD       7
`define TTXW_B_LAST_ACT8 6
`define TTXW_B_PROTO     5
`define TTXW_B_FIRST_ACT8 4
`define TTXW_B_EVN_LAST8 3
`define TTXW_B_ODD_LAST8 2
`define TTXW_B_EVN_FIRST8 1
`define TTXW_B_ODD_FIRST8 0

// Reset values, PAL strap then NTSC strap
`define TTXW_R_ODD_FIRST_PAL  8'h05
`define TTXW_R_ODD_FIRST_NTSC 8'h06
`define TTXW_R_LAST_PAL       8'h16
`define TTXW_R_LAST_NTSC      8'h10
`define TTXW_R_EVN_FIRST_PAL  8'h04
`define TTXW_R_EVN_FIRST_NTSC 8'h05
`define TTXW_R_ZERO           8'h00

// Row offsets for start and end values
`define TTXW_ADD_START_525 9'h004
`define TTXW_ADD_START_625 9'h001
`define TTXW_ADD_END_525   9'h003
`define TTXW_ADD_END_625   9'h000
// Mask covers rows 5 to 20 in 625 counting
`define TTXW_MASK_FIRST    9'h005
`define TTXW_MASK_LAST     9'h014

// Timing counts; latency covers pin flop plus sync and agreement stages
`define TTXW_SYNC_LAT      5'h05
`define TTXW_DELAY_MIN     4'h2

// Standard codes on the standard output
`define TTXW_STD_EURO  2'h0
`define TTXW_STD_NABTS 2'h1
`define TTXW_STD_WST60 2'h2

`endif

// file: ttxw_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ttxw_sync3 (
	input  wire clk_sys,
	input  wire rst_b,
	input  wire pin_in,
	output reg  level
);
	reg s1;
	reg s2;
	reg s3;

	// Stage one feeds only stage two
	always @(posedge clk_sys) begin
		s1 <= pin_in;
		s2 <= s1;
		s3 <= s2;
	end

	// Change counts once stages two and three agree
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule // ttxw_sync3
`default_nettype wire

// file: ttxw_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ttxw_buf2 #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         rst_b,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output reg  [W-1:0] out_data,
	output reg          out_valid,
	input  wire         out_ready
);
	reg [W-1:0] spare;
	reg         spare_valid;

	// Spare entry absorbs one word while the drain stalls
	assign in_ready = !spare_valid;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			out_valid   <= 1'b0;
			spare_valid <= 1'b0;
			out_data    <= {W{1'b0}};
			spare       <= {W{1'b0}};
		end else begin
			if (!out_valid || out_ready) begin
				if (spare_valid) begin
					out_data    <= spare;
					out_valid   <= 1'b1;
					spare_valid <= in_valid;
					spare       <= in_data;
				end else begin
					out_data  <= in_data;
					out_valid <= in_valid;
				end
			end else if (in_valid && !spare_valid) begin
				spare       <= in_data;
				spare_valid <= 1'b1;
			end
		end
	end
endmodule // ttxw_buf2
`default_nettype wire

// file: ttxw_timing_asserts.sv
// Port checks for the teletext line window timing block
`timescale 1ns/1ps
`default_nettype none
module ttxw_timing_asserts (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       field_rate_select,
	input wire logic       second_clock_output_enable,
	input wire logic       shared_request_clock_pin,
	input wire logic       shared_request_clock_pin_oe,
	input wire logic [1:0] teletext_standard,
	input wire logic       bit_data,
	input wire logic       bit_valid,
	input wire logic       bit_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Pin ownership follows the second clock enable
	a_oe_follow: assert property (1 |=> shared_request_clock_pin_oe
		== !$past(second_clock_output_enable)) else $error("pin enable lags wrong");
	a_pin_owned: assert property (shared_request_clock_pin |-> shared_request_clock_pin_oe)
		else $error("request without pin enable");
	a_clk2_quiet: assert property (second_clock_output_enable [*2] |-> !shared_request_clock_pin)
		else $error("request while second clock owns pin");
	// Standard code follows the field rate
	a_std_fifty: assert property (!field_rate_select [*2] |-> teletext_standard == 2'h0)
		else $error("50 Hz standard wrong");
	a_std_sixty: assert property (field_rate_select [*2] |-> teletext_standard != 2'h0)
		else $error("60 Hz standard wrong");
	// A stalled word stays put, each request edge yields a word
	a_stall_hold: assert property (bit_valid && !bit_ready |=> bit_valid && $stable(bit_data))
		else $error("stalled bit lost");
	a_edge_bit: assert property ($rose(shared_request_clock_pin) |-> ##[1:24] bit_valid)
		else $error("request edge gave no bit");
	a_rd_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without read");
endmodule // ttxw_timing_asserts

bind ttxw_timing ttxw_timing_asserts u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.field_rate_select(field_rate_select),
	.second_clock_output_enable(second_clock_output_enable),
	.shared_request_clock_pin(shared_request_clock_pin),
	.shared_request_clock_pin_oe(shared_request_clock_pin_oe),
	.teletext_standard(teletext_standard), .bit_data(bit_data),
	.bit_valid(bit_valid), .bit_ready(bit_ready)
);
`default_nettype wire

// file: ttxw_src_model.sv
// Behavioural teletext data source
`timescale 1ns/1ps
`default_nettype none
module ttxw_src_model (
	input  wire logic       clk_sys,
	input  wire logic       req,
	input  wire logic [3:0] dly,
	output var  logic       dat
);
	int   idx = 0;
	int   cnt = 0;
	logic req_q = 1'b0;
	initial dat = 1'b0;
	// New bit per edge; old bit shows inverted until the delay is over
	always @(posedge clk_sys) begin
		req_q <= req;
		if (req && !req_q) begin
			idx <= idx + 1;
			cnt <= 2;
			dat <= ~dat;
		end else if (cnt != 0) begin
			if (cnt >= dly) begin
				dat <= idx[0] ^ idx[1];
				cnt <= 0;
			end else
				cnt <= cnt + 1;
		end
	end
endmodule // ttxw_src_model
`default_nettype wire

// file: tb.sv
// Testbench for the teletext line window timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys, rst_b, strap, reg_wr, reg_rd, fsync, fodd, lstart, frs, sce;
	logic        ttx_in, pin, pin_oe, act, bit_data, bit_valid, bit_ready, pin_q, chk_val;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, os, ol, es, el, md;
	logic [15:0] mask;
	logic [3:0]  dly;
	logic [1:0]  std;
	int          failures, num_checks, rises, bits, rx, stall_k, nb;

	ttxw_timing #(.BITS_EURO(4), .BITS_NABTS(3), .BITS_WST60(5), .BIT_PERIOD(4)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .strap_ntsc(strap), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.field_sync(fsync), .field_odd(fodd), .line_start(lstart),
		.field_rate_select(frs), .second_clock_output_enable(sce),
		.request_to_data_delay(dly), .teletext_data_input(ttx_in),
		.shared_request_clock_pin(pin), .shared_request_clock_pin_oe(pin_oe),
		.active_row(act), .teletext_standard(std), .bit_data(bit_data),
		.bit_valid(bit_valid), .bit_ready(bit_ready));
	ttxw_src_model src (.clk_sys(clk_sys), .req(pin & pin_oe), .dly(dly), .dat(ttx_in));

	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Cuts a hung run short
	initial begin
		#1000000;
		failures++;
		wrap_up();
	end
	// Counts request edges on the wire and takes in captured bits
	always @(posedge clk_sys) begin
		pin_q <= pin & pin_oe;
		if ((pin & pin_oe) === 1'b1 && pin_q === 1'b0) rises++;
		if (bit_valid === 1'b1 && bit_ready) begin
			bits++;
			rx++;
			if (chk_val) check("bit_data", bit_data, rx[0] ^ rx[1]);
		end
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, e);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk_sys);
		check("reg_rdata", reg_rdata, e);
		reg_rd = 0;
		@(negedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk_sys);
		reg_wr = 0;
		rd(a, d);
	endtask
	task automatic cfg(input logic [7:0] a, b, c, d, fa, la, m, input logic [15:0] k);
		os = a; ol = b; es = c; el = d; md = m; mask = k;
		wr(8'h76, a); wr(8'h77, b); wr(8'h78, c); wr(8'h79, d); wr(8'h7A, fa);
		wr(8'h7B, la); wr(8'h7C, m); wr(8'h7E, k[7:0]); wr(8'h7F, k[15:8]);
		nb = frs ? (m[7] ? 5 : 3) : 4;
		check("standard", std, frs ? (m[7] ? 2'h2 : 2'h1) : 2'h0);
	endtask
	// One field; line k carries row k, or k+3 on 525-line timing
	task automatic field(input logic odd, input int nl, input logic post, input int cnt);
		int   st, en, n_act;
		logic inw;
		fodd = odd;
		fsync = 1;
		@(negedge clk_sys);
		fsync = 0;
		n_act = 0;
		repeat (5) @(negedge clk_sys);
		check("active_row", act, post);
		for (int k = 1; k <= nl; k++) begin
			st = (odd ? os : es) + (frs ? 4 : 1);
			en = (odd ? ol : el) + (frs ? 3 : 0);
			inw = (k + (frs ? 3 : 0) >= st) && (k + (frs ? 3 : 0) <= en) && !sce
				&& !(k >= 5 && k <= 20 && mask[k-5]);
			rises = 0;
			bits = 0;
			lstart = 1;
			@(negedge clk_sys);
			lstart = 0;
			bit_ready = (k != stall_k);
			repeat (100) @(negedge clk_sys);
			n_act += (act === 1'b1);
			bit_ready = 1;
			repeat (100) @(negedge clk_sys);
			check("requests", rises, inw ? (md[5] ? 1 : nb) : 0);
			if (!sce) check("bits", bits, inw ? nb : 0);
		end
		if (cnt >= 0) check("active_rows", n_act, cnt);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_b = 0; strap = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
		fsync = 0; fodd = 0; lstart = 0; frs = 0; sce = 0; dly = 0; bit_ready = 1;
		chk_val = 1; stall_k = 0; failures = 0; num_checks = 0; rises = 0; bits = 0; rx = 0;
		for (int s = 0; s < 2; s++) begin
			strap = s[0];
			rst_b = 0;
			repeat (2) @(negedge clk_sys);
			rst_b = 1;
			repeat (2) @(negedge clk_sys);
			rd(8'h76, s ? 8'h06 : 8'h05);
			rd(8'h77, s ? 8'h10 : 8'h16);
			rd(8'h78, s ? 8'h05 : 8'h04);
			rd(8'h79, s ? 8'h10 : 8'h16);
			rd(8'h7C, 8'h00);
			rd(8'h80, 8'h00);
		end
		$display("test reset_values done");
		stall_k = 6;
		cfg(8'h05, 8'h0A, 8'h0C, 8'h0D, 8'h02, 8'h05, 8'h00, 16'h0008);
		field(1, 12, 0, 3);
		stall_k = 0;
		field(0, 14, 0, 3);
		$display("test rows_625 done");
		frs = 1;
		dly = 4'h5;
		for (int t = 0; t < 2; t++) begin
			cfg(8'h02, 8'h05, 8'h0C, 8'h0D, 8'h00, 8'h04, t ? 8'h80 : 8'h00, 16'h0001);
			field(1, 9, 1, -1);
		end
		$display("test rows_525 done");
		frs = 0;
		dly = 4'h0;
		chk_val = 0;
		cfg(8'h05, 8'h0A, 8'h0C, 8'h0D, 8'h02, 8'h05, 8'h30, 16'h0008);
		field(1, 12, 0, 0);
		sce = 1;
		field(1, 12, 0, -1);
		$display("test window_protocol done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
